// [uart_ctl_pkg.sv]
// constants shared by the modem, reset and host control logic of the serial controller
package uart_ctl_pkg;
  // register word offsets on the wishbone bus (byte addresses)
  localparam logic [4:0] OFF_DATA      = 5'h00; // write: tx holding, read: rx holding
  localparam logic [4:0] OFF_FMT_STAT  = 5'h04; // write: line format, read: uart status
  localparam logic [4:0] OFF_MODEM     = 5'h08; // modem control, read and write
  localparam logic [4:0] OFF_RATE_MSTA = 5'h0c; // write: bit-rate select, read: modem status
  localparam logic [4:0] OFF_IRQ_STAT  = 5'h10; // sticky event flags, write one to clear
  localparam logic [4:0] OFF_IRQ_MASK  = 5'h14; // event mask, same layout
  localparam logic [4:0] OFF_FMT_READ  = 5'h18; // readback of line format and bit-rate select
  // modem control bit positions
  localparam int MC_DTR    = 0;
  localparam int MC_RTS    = 1;
  localparam int MC_IRQ_GLOBAL_EN  = 2;
  localparam int MC_MODEM_IRQ_EN   = 3;
  localparam int MC_MODE_L = 4; // two bits: operating mode
  localparam int MC_RX_EN  = 6;
  // operating modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_BREAK  = 2'h1;
  localparam logic [1:0] MODE_ECHO   = 2'h2;
  localparam logic [1:0] MODE_LOOP   = 2'h3;
  // uart status bit positions
  localparam int US_RX_READY = 0;
  localparam int US_OVERRUN  = 1;
  localparam int US_FRAMING  = 2;
  localparam int US_TX_EMPTY = 6;
  localparam int US_TX_DONE  = 7;
  // bit-rate select: clock-out select bit
  localparam int BR_CO_SEL = 7;
  // interrupt event bit positions and event vector width
  localparam int EV_RX    = 0;
  localparam int EV_TX    = 1;
  localparam int EV_MODEM = 2;
  localparam int EV_W     = 3;
  // reset values
  localparam logic [7:0] MODEM_RST    = 8'h00;
  localparam logic [7:0] STATUS_RST   = 8'hc0; // tx done and tx holding empty set
  localparam logic [7:0] FORMAT_PON   = 8'h00; // power-on value only
  localparam logic [7:0] RATE_PON     = 8'h00; // power-on value only
  // timing counts in 16x ticks, frame and data lengths in bits
  localparam logic [3:0] TICKS_BIT    = 4'hf; // last tick of one bit time
  localparam logic [3:0] TICKS_HALF   = 4'h7; // mid-bit sample point
  localparam logic [3:0] FRAME_BITS   = 4'ha; // start, eight data, stop
  localparam logic [3:0] DATA_BITS    = 4'h8;
endpackage : uart_ctl_pkg

// [uart_modem_reset_control.sv]
// modem handshake, interrupt, clock-out and reset control of the serial controller
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
module uart_modem_reset_control
  import uart_ctl_pkg::*;
#(
  parameter int DIV_W = 8 // width of the 16x tick divider
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        uart_rst,
  input  wire logic        chip_sel_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        osc_input,
  input  wire logic        serial_in,
  output logic             serial_out,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             clk_out_pin,
  output logic             tx_holding_empty,
  output logic             rx_ready,
  output logic             irq_out
);

  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11} rx_state_e;
  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_e;

  logic [7:0]       modem_ctrl_reg;      // modem control
  logic [7:0]       line_format_reg;     // line format, kept through uart reset
  logic [7:0]       bitrate_select_reg;  // divider and clock-out select
  logic [7:0]       tx_holding_reg;      // character waiting to be sent
  logic [7:0]       rx_holding_reg;      // last received character
  logic [7:0]       uart_status_reg;     // status flags
  logic [EV_W-1:0]  irq_stat_reg;        // sticky events
  logic [EV_W-1:0]  irq_mask_reg;        // event mask
  logic [EV_W-1:0]  ev_set;              // events this cycle
  logic [DIV_W-1:0] div_cnt_reg;         // 16x tick divider
  logic             tick16;              // one-cycle 16x enable
  logic             co_toggle_reg;       // square wave at half the 16x rate for the clock-out pin
  logic [2:0]       cts_sync_reg;        // two sync stages and one history
  logic [2:0]       dsr_sync_reg;        // two sync stages and one history
  logic             modem_change;        // handshake level changed
  tx_state_e        tx_state_reg;
  logic [9:0]       tx_shift_reg;        // frame being sent, lsb first
  logic [3:0]       tx_tick_reg;         // ticks within a tx bit
  logic [3:0]       tx_bit_reg;          // tx bit counter
  logic             tx_load;             // holding register hands off
  rx_state_e        rx_state_reg;
  logic [7:0]       rx_shift_reg;        // data bits being collected
  logic [3:0]       rx_tick_reg;         // ticks within an rx bit
  logic [3:0]       rx_bit_reg;          // rx bit counter
  logic             rx_line;             // receiver input after mode gating
  logic             rx_done;             // character completed
  logic             acc;                 // new bus request, chip selected
  logic             wr;                  // register write this cycle
  logic             rd;                  // register read this cycle
  logic [1:0]       mode;                // operating mode
  logic             cts_true;            // cts asserted, synchronised

  // a byte lane 0 write to the given offset
  function automatic logic wr_hit(input logic [4:0] off);
    wr_hit = wr && (wb_adr_i == off) && wb_sel_i[0];
  endfunction

  assign mode     = modem_ctrl_reg[MC_MODE_L +: 2];
  assign cts_true = ~cts_sync_reg[1];
  assign acc      = wb_cyc_i && wb_stb_i && !wb_ack_o && !chip_sel_n;
  assign wr       = acc && wb_we_i;
  assign rd       = acc && !wb_we_i;

  // wishbone ack: one cycle after the request, also for a deselected chip so the bus never hangs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // read data mux, registered with the ack
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= 32'h0;
      if (rd) begin
        case (wb_adr_i)
          OFF_DATA:      wb_dat_o[7:0] <= rx_holding_reg;
          OFF_FMT_STAT:  wb_dat_o[7:0] <= uart_status_reg;
          OFF_MODEM:     wb_dat_o[7:0] <= modem_ctrl_reg;
          OFF_RATE_MSTA: wb_dat_o[1:0] <= {~dsr_sync_reg[1], cts_true};
          OFF_IRQ_STAT:  wb_dat_o[EV_W-1:0] <= irq_stat_reg;
          OFF_IRQ_MASK:  wb_dat_o[EV_W-1:0] <= irq_mask_reg;
          OFF_FMT_READ:  wb_dat_o[15:0] <= {bitrate_select_reg, line_format_reg};
          default:       wb_dat_o <= 32'h0;                                  // unmapped reads zero
        endcase
      end
    end
  end

  // modem control: cleared by power-on and by the uart reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modem_ctrl_reg <= MODEM_RST;
    end else if (uart_rst) begin
      modem_ctrl_reg <= MODEM_RST;
    end else if (wr_hit(OFF_MODEM)) begin
      modem_ctrl_reg <= wb_dat_i[7:0];
    end
  end

  // line format: only power-on sets it, uart reset leaves it alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_format_reg <= FORMAT_PON;
    end else if (wr_hit(OFF_FMT_STAT)) begin
      line_format_reg <= wb_dat_i[7:0];
    end
  end

  // bit-rate select: uart reset clears only the clock-out select
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitrate_select_reg <= RATE_PON;
    end else if (uart_rst) begin
      bitrate_select_reg[BR_CO_SEL] <= 1'b0;
    end else if (wr_hit(OFF_RATE_MSTA)) begin
      bitrate_select_reg <= wb_dat_i[7:0];
    end
  end

  // handshake outputs follow their control bits, inverted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
    end else begin
      dtr_n <= uart_rst ? 1'b1 : ~modem_ctrl_reg[MC_DTR];
      rts_n <= uart_rst ? 1'b1 : ~modem_ctrl_reg[MC_RTS];
    end
  end

  // handshake synchronisers; change seen between second stage and history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cts_sync_reg <= 3'h7;
      dsr_sync_reg <= 3'h7;
    end else begin
      cts_sync_reg <= {cts_sync_reg[1:0], cts_n};
      dsr_sync_reg <= {dsr_sync_reg[1:0], dsr_n};
    end
  end
  assign modem_change = (cts_sync_reg[2] ^ cts_sync_reg[1]) | (dsr_sync_reg[2] ^ dsr_sync_reg[1]);

  // 16x tick divider: period is the low seven rate bits plus one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_reg <= '0;
    end else if (uart_rst || div_cnt_reg >= DIV_W'(bitrate_select_reg[6:0])) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end
  assign tick16 = !uart_rst && (div_cnt_reg >= DIV_W'(bitrate_select_reg[6:0]));

  // clock out: sampled oscillator, or a square wave at half the 16x rate (one toggle per tick)
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      co_toggle_reg <= 1'b0;
      clk_out_pin   <= 1'b0;
    end else begin
      if (uart_rst) begin
        co_toggle_reg <= 1'b0;
      end else if (tick16) begin
        co_toggle_reg <= ~co_toggle_reg;
      end
      clk_out_pin <= bitrate_select_reg[BR_CO_SEL] ? co_toggle_reg : osc_input;
    end
  end

  // new characters start only with cts true, outside echo, in the idle state
  assign tx_load = (tx_state_reg == TX_IDLE) && !uart_status_reg[US_TX_EMPTY] && cts_true
                   && (mode != MODE_ECHO) && !uart_rst;

  // transmit holding register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_holding_reg <= 8'h0;
    end else if (wr_hit(OFF_DATA)) begin
      tx_holding_reg <= wb_dat_i[7:0];
    end
  end

  // transmit shifter; a character under way is finished even if cts drops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 10'h3ff;
      tx_tick_reg  <= 4'h0;
      tx_bit_reg   <= 4'h0;
    end else if (uart_rst) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 10'h3ff;
      tx_tick_reg  <= 4'h0;
      tx_bit_reg   <= 4'h0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_load) begin
            tx_shift_reg <= (mode == MODE_BREAK) ? 10'h000 : {1'b1, tx_holding_reg, 1'b0};
            tx_tick_reg  <= 4'h0;
            tx_bit_reg   <= 4'h0;
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tick16) begin
            tx_tick_reg <= tx_tick_reg + 1'b1;
            if (tx_tick_reg == TICKS_BIT) begin
              tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
              tx_bit_reg   <= tx_bit_reg + 1'b1;
              if (tx_bit_reg == FRAME_BITS - 4'h1) begin
                tx_state_reg <= TX_IDLE;
              end
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // serial output: mark in loop, reset, or idle outside echo (also with cts false between characters); echo follows serial_in
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out <= 1'b1;
    end else if (uart_rst || mode == MODE_LOOP) begin
      serial_out <= 1'b1;
    end else if (mode == MODE_ECHO) begin
      serial_out <= serial_in;
    end else if (tx_state_reg == TX_IDLE) begin
      serial_out <= 1'b1;
    end else begin
      serial_out <= tx_shift_reg[0];
    end
  end

  // receiver input: pin ignored in loop mode and during reset
  assign rx_line = uart_rst || !modem_ctrl_reg[MC_RX_EN] ? 1'b1 :
                   (mode == MODE_LOOP) ? ((tx_state_reg == TX_IDLE) | tx_shift_reg[0]) : serial_in;

  // receive state machine: confirm start at mid-bit, then sample each bit at mid-bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= 8'h0;
      rx_tick_reg  <= 4'h0;
      rx_bit_reg   <= 4'h0;
    end else if (uart_rst) begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg  <= 4'h0;
      rx_bit_reg   <= 4'h0;
    end else if (tick16) begin
      rx_tick_reg <= rx_tick_reg + 1'b1;
      case (rx_state_reg)
        RX_IDLE: begin
          rx_tick_reg <= 4'h0;
          if (!rx_line) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick_reg == TICKS_HALF) begin
            rx_tick_reg  <= 4'h0;
            rx_bit_reg   <= 4'h0;
            rx_state_reg <= rx_line ? RX_IDLE : RX_DATA; // false start returns to idle
          end
        end
        RX_DATA: begin
          if (rx_tick_reg == TICKS_BIT) begin
            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 1'b1;
            if (rx_bit_reg == DATA_BITS - 4'h1) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick_reg == TICKS_BIT) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end
  assign rx_done = tick16 && !uart_rst && (rx_state_reg == RX_STOP) && (rx_tick_reg == TICKS_BIT);

  // receive holding register loads at the stop bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_holding_reg <= 8'h0;
    end else if (rx_done) begin
      rx_holding_reg <= rx_shift_reg;
    end
  end

  // uart status: reset sets the two tx flags and clears the rest
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      uart_status_reg <= STATUS_RST;
    end else if (uart_rst) begin
      uart_status_reg <= STATUS_RST;
    end else begin
      if (wr_hit(OFF_DATA)) begin
        uart_status_reg[US_TX_EMPTY] <= 1'b0;
      end else if (tx_load) begin
        uart_status_reg[US_TX_EMPTY] <= 1'b1;
      end
      if (tx_load) begin
        uart_status_reg[US_TX_DONE] <= 1'b0;
      end else if (tx_state_reg == TX_SHIFT && tx_state_reg != TX_IDLE && tick16 && tx_tick_reg == TICKS_BIT
                   && tx_bit_reg == FRAME_BITS - 4'h1 && uart_status_reg[US_TX_EMPTY]) begin
        uart_status_reg[US_TX_DONE] <= 1'b1;
      end
      // received character: set wins over the read that clears
      if (rx_done) begin
        uart_status_reg[US_RX_READY] <= 1'b1;
        uart_status_reg[US_OVERRUN]  <= uart_status_reg[US_RX_READY];
        uart_status_reg[US_FRAMING]  <= !rx_line;
      end else if (rd && wb_adr_i == OFF_DATA) begin
        uart_status_reg[US_RX_READY] <= 1'b0;
      end else if (rd && wb_adr_i == OFF_FMT_STAT) begin
        uart_status_reg[US_OVERRUN] <= 1'b0;
        uart_status_reg[US_FRAMING] <= 1'b0;
      end
    end
  end

  // discrete status pins mirror their flags one cycle later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_holding_empty <= 1'b1;
      rx_ready         <= 1'b0;
    end else begin
      tx_holding_empty <= uart_rst | uart_status_reg[US_TX_EMPTY];
      rx_ready         <= !uart_rst & uart_status_reg[US_RX_READY];
    end
  end

  // events; a modem change only counts with its own enable
  assign ev_set[EV_RX]    = rx_done;
  assign ev_set[EV_TX]    = tx_load;
  assign ev_set[EV_MODEM] = modem_change && modem_ctrl_reg[MC_MODEM_IRQ_EN];

  // sticky event flags, write one to clear, a new event wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      if (uart_rst) begin
        irq_stat_reg <= '0;
      end else if (wr_hit(OFF_IRQ_STAT)) begin
        irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[EV_W-1:0]) | ev_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev_set;
      end
      if (wr_hit(OFF_IRQ_MASK)) begin
        irq_mask_reg <= wb_dat_i[EV_W-1:0];
      end
    end
  end

  // interrupt pin: global enable gates everything, modem bit also needs its enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= modem_ctrl_reg[MC_IRQ_GLOBAL_EN] && !uart_rst
                 && |(irq_stat_reg & irq_mask_reg & {modem_ctrl_reg[MC_MODEM_IRQ_EN], 2'b11});
    end
  end

endmodule // uart_modem_reset_control

// [uart_ctl_assertions.sv]
// concurrent checks on the ports of the modem and reset control block
`timescale 1ns/10ps
module uart_ctl_assertions
  import uart_ctl_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        uart_rst,
  input wire logic        chip_sel_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        serial_out,
  input wire logic        dsr_n,
  input wire logic        dtr_n,
  input wire logic        rts_n,
  input wire logic        tx_holding_empty,
  input wire logic        rx_ready,
  input wire logic        irq_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a taken request is answered at the next edge, for one cycle
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not a one cycle answer");
  // deselected read returns zero
  property p_cs_read; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && chip_sel_n |=> wb_dat_o == 32'h0; endproperty
  a_cs_read: assert property (p_cs_read) else $error("deselected read not zero");
  // device reset releases both handshake outputs
  property p_rst_modem; uart_rst |=> dtr_n && rts_n; endproperty
  a_rst_modem: assert property (p_rst_modem) else $error("handshake outputs not high in reset");
  // device reset sets holding empty, clears ready and irq
  property p_rst_flags; uart_rst |=> tx_holding_empty && !rx_ready && !irq_out; endproperty
  a_rst_flags: assert property (p_rst_flags) else $error("flags wrong in reset");
  // device reset holds the line in mark
  property p_rst_mark; uart_rst |=> serial_out; endproperty
  a_rst_mark: assert property (p_rst_mark) else $error("line not mark in reset");
  // terminal ready moves only after a bus write or reset, never from dsr
  property p_dtr_cause; $changed(dtr_n) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(uart_rst); endproperty
  a_dtr_cause: assert property (p_dtr_cause) else $error("dtr moved without cause");
  // send request moves only after a bus write or reset
  property p_rts_cause; $changed(rts_n) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(uart_rst); endproperty
  a_rts_cause: assert property (p_rts_cause) else $error("rts moved without cause");
  // ready falls only after a bus read or reset
  property p_rdy_fall; $fell(rx_ready) |-> $past(wb_ack_o && !wb_we_i) || $past(uart_rst); endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("rx ready fell without read");
  // holding empty falls only after a bus write
  property p_tbe_fall; $fell(tx_holding_empty) |-> $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2); endproperty
  a_tbe_fall: assert property (p_tbe_fall) else $error("holding empty fell without write");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_irq: cover property ($rose(irq_out));
  c_rx: cover property ($rose(rx_ready));
endmodule // uart_ctl_assertions
bind uart_modem_reset_control uart_ctl_assertions u_uart_ctl_assertions (.clk(clk), .reset_n(reset_n),
  .uart_rst(uart_rst), .chip_sel_n(chip_sel_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_out(serial_out), .dsr_n(dsr_n), .dtr_n(dtr_n),
  .rts_n(rts_n), .tx_holding_empty(tx_holding_empty), .rx_ready(rx_ready), .irq_out(irq_out));

// [modem_peer.sv]
// far-end modem peer: returns the line, drives handshakes and the oscillator
`timescale 1ns/10ps
module modem_peer (
  input  wire logic clk,
  input  wire logic serial_out,
  input  wire logic line_back,
  input  wire logic dsr_on,
  input  wire logic cts_on,
  output logic      serial_in,
  output logic      dsr_n,
  output logic      cts_n,
  output logic      osc_input
);
  logic [1:0] osc_cnt_reg; // divides the oscillator stand-in
  // known levels from time zero
  initial begin
    osc_cnt_reg = 2'h0;
    osc_input = 1'b0;
    dsr_n = 1'b1;
    cts_n = 1'b1;
  end
  // line echoes the transmit level, or holds a break when cut
  assign serial_in = line_back ? serial_out : 1'b0;
  // handshakes active low, changed just after an edge
  always @(posedge clk) begin
    dsr_n <= ~dsr_on;
    cts_n <= ~cts_on;
  end
  // oscillator toggles every third cycle
  always @(posedge clk) begin
    osc_cnt_reg <= (osc_cnt_reg == 2'h2) ? 2'h0 : osc_cnt_reg + 2'h1;
    if (osc_cnt_reg == 2'h2) osc_input <= ~osc_input;
  end
endmodule // modem_peer

// [uart_modem_reset_control_test.sv]
// self-checking bench for the modem, reset and clock-out control block
`timescale 1ns/10ps
module uart_modem_reset_control_test;
  import uart_ctl_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, uart_rst = 1'b0, chip_sel_n = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic        wb_ack_o, osc_input, serial_in, serial_out, cts_n, dsr_n, dtr_n, rts_n;
  logic        clk_out_pin, tx_holding_empty, rx_ready, irq_out, bad;
  logic        line_back = 1'b1, dsr_on = 1'b0, cts_on = 1'b0;
  int          error_cnt = 0, num_checks = 0, i, n;
  always #25 clk = ~clk;
  uart_modem_reset_control #(.DIV_W(8)) u_uart_modem_reset_control (.clk(clk), .reset_n(reset_n),
    .uart_rst(uart_rst), .chip_sel_n(chip_sel_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .osc_input(osc_input), .serial_in(serial_in), .serial_out(serial_out), .cts_n(cts_n), .dsr_n(dsr_n),
    .dtr_n(dtr_n), .rts_n(rts_n), .clk_out_pin(clk_out_pin), .tx_holding_empty(tx_holding_empty),
    .rx_ready(rx_ready), .irq_out(irq_out));
  modem_peer u_modem_peer (.clk(clk), .serial_out(serial_out), .line_back(line_back), .dsr_on(dsr_on),
    .cts_on(cts_on), .serial_in(serial_in), .dsr_n(dsr_n), .cts_n(cts_n), .osc_input(osc_input));
  // counts and verdict, then end of run
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // a bounded wait that ran out ends the run
  task tmo(input logic ok);
    chk(ok, 1'b1);
    if (ok !== 1'b1) stop_test();
  endtask
  task waitc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // classic single wishbone cycle, held until ack
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= {24'h0, d};
    n = 0;
    do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    tmo(n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
  endtask
  // device reset held past two oscillator periods (six clocks each)
  task rst_pulse;
    @(posedge clk); uart_rst <= 1'b1;
    waitc(13); uart_rst <= 1'b0;
    @(posedge clk);
  endtask
  // clock out follows the oscillator one cycle late
  task osc_follow;
    logic p;
    bad = 1'b0;
    for (i = 0; i < 12; i++) begin p = osc_input; @(posedge clk); if (clk_out_pin !== p) bad = 1'b1; end
  endtask
  // reset state of outputs and status
  task t_reset;
    chk({dtr_n, rts_n, tx_holding_empty, rx_ready, irq_out, serial_out}, 6'b111001);
    bus(1'b0, OFF_FMT_STAT, 8'h00); chk(rdat, 32'hc0);
    $display("test reset done");
  endtask
  // handshake outputs, chip select, readback, reset clear
  task t_modem;
    bus(1'b1, OFF_MODEM, 8'h01); waitc(2); chk({dtr_n, rts_n}, 2'b01);
    bus(1'b1, OFF_MODEM, 8'h02); waitc(2); chk({dtr_n, rts_n}, 2'b10);
    chip_sel_n <= 1'b1;
    bus(1'b1, OFF_MODEM, 8'h01); bus(1'b0, OFF_MODEM, 8'h00); chk(rdat, 32'h0);
    chip_sel_n <= 1'b0;
    bus(1'b0, OFF_MODEM, 8'h00); chk(rdat, 32'h02);
    bus(1'b0, 5'h1c, 8'h00); chk(rdat, 32'h0);
    bus(1'b1, OFF_MODEM, 8'h03); rst_pulse(); chk({dtr_n, rts_n}, 2'b11);
    bus(1'b0, OFF_MODEM, 8'h00); chk(rdat, 32'h0);
    $display("test modem done");
  endtask
  // dsr change interrupt under both enables and the mask
  task t_dsr;
    bus(1'b1, OFF_IRQ_MASK, 8'h04); bus(1'b1, OFF_MODEM, 8'h0c); dsr_on <= 1'b1;
    for (i = 0; i < 12 && irq_out !== 1'b1; i++) @(posedge clk);
    tmo(irq_out);
    bus(1'b0, OFF_RATE_MSTA, 8'h00); chk(rdat, 32'h02);
    bus(1'b1, OFF_IRQ_STAT, 8'h04); waitc(2); chk(irq_out, 1'b0);
    bus(1'b1, OFF_MODEM, 8'h08); dsr_on <= 1'b0; waitc(8); chk(irq_out, 1'b0);
    bus(1'b1, OFF_MODEM, 8'h0c); waitc(2); chk(irq_out, 1'b1);
    bus(1'b1, OFF_IRQ_STAT, 8'h04); bus(1'b1, OFF_MODEM, 8'h04); dsr_on <= 1'b1; waitc(8);
    chk(irq_out, 1'b0);
    bus(1'b0, OFF_IRQ_STAT, 8'h00); chk(rdat, 32'h0);
    $display("test dsr done");
  endtask
  // clock-out select, rate bits and format through reset
  task t_clk;
    bus(1'b1, OFF_FMT_STAT, 8'h15); bus(1'b1, OFF_RATE_MSTA, 8'h03); waitc(3);
    osc_follow(); chk(bad, 1'b0);
    bus(1'b1, OFF_RATE_MSTA, 8'h83); waitc(4); n = 0;
    for (i = 0; i < 64; i++) begin bad = clk_out_pin; @(posedge clk); if (clk_out_pin !== bad) n++; end
    chk(n >= 15 && n <= 17, 1'b1);
    rst_pulse(); bus(1'b0, OFF_FMT_READ, 8'h00); chk(rdat, 32'h0315);
    osc_follow(); chk(bad, 1'b0);
    $display("test clock_out done");
  endtask
  // clear-to-send gating, holding empty, receive ready
  task t_serial;
    bus(1'b1, OFF_RATE_MSTA, 8'h00); bus(1'b1, OFF_MODEM, 8'h40); bus(1'b1, OFF_DATA, 8'h3c); bad = 1'b0;
    for (i = 0; i < 250; i++) begin @(posedge clk); if (serial_out !== 1'b1) bad = 1'b1; end
    chk(bad, 1'b0);
    chk(tx_holding_empty, 1'b0);
    cts_on <= 1'b1;
    for (i = 0; i < 100 && tx_holding_empty !== 1'b1; i++) @(posedge clk);
    tmo(tx_holding_empty);
    for (i = 0; i < 600 && rx_ready !== 1'b1; i++) @(posedge clk);
    tmo(rx_ready);
    bus(1'b0, OFF_DATA, 8'h00); chk(rdat, 32'h3c);
    waitc(2); chk(rx_ready, 1'b0);
    bus(1'b1, OFF_DATA, 8'hc3); waitc(40); cts_on <= 1'b0;
    for (i = 0; i < 600 && rx_ready !== 1'b1; i++) @(posedge clk);
    tmo(rx_ready);
    bus(1'b0, OFF_DATA, 8'h00); chk(rdat, 32'hc3);
    rst_pulse(); chk(rx_ready, 1'b0);
    bus(1'b0, OFF_FMT_STAT, 8'h00); chk(rdat, 32'hc0);
    $display("test serial done");
  endtask
  // loop mode ignores a break on the receive line
  task t_loop;
    cts_on <= 1'b1; bus(1'b1, OFF_MODEM, 8'h70); line_back <= 1'b0; waitc(300);
    chk({rx_ready, serial_out}, 2'b01);
    bus(1'b0, OFF_FMT_STAT, 8'h00); chk(rdat, 32'hc0);
    line_back <= 1'b1; waitc(2); bus(1'b1, OFF_MODEM, 8'h00);
    $display("test loop done");
  endtask
  // main sequence
  initial begin
    waitc(16); reset_n <= 1'b1;
    rst_pulse();
    t_reset(); t_modem(); t_dsr(); t_clk(); t_serial(); t_loop();
    stop_test();
  end
endmodule // uart_modem_reset_control_test
